// File: hdl/cic_top.sv
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module cic_top #(
    parameter int N_IN = 8,
    parameter int FILT_N_LONG = cic_pkg::FILT_N_LONG
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [N_IN-1:0] function_pin,
    input wire logic backplane_10mhz_clock,
    output logic [N_IN-1:0] filtered_in,
    output logic [N_IN-1:0] trigger_bus_line,
    output logic [1:0] internal_out,
    output logic [1:0] terminal_count,
    output logic [1:0] latch_valid,
    output logic [31:0] count_value [2],
    output logic [31:0] latch_value [2]
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and AXI4-Lite slave.

    cic_pkg::cic_ctrl_t ctrl [2];
    logic [31:0] filt_cfg;
    logic [N_IN-1:0] route_direct;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_held;
    logic w_held;
    logic [1:0] cnt_load;
    logic [31:0] load_data;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    wire do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr[7:0];
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl[0] <= cic_pkg::CTRL_RESET;
            ctrl[1] <= cic_pkg::CTRL_RESET;
            filt_cfg <= cic_pkg::FILT_RESET;
            route_direct <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= cic_pkg::RESP_OKAY;
            cnt_load <= 2'b00;
            load_data <= 32'h0000_0000;
        end else begin
            cnt_load <= 2'b00;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= cic_pkg::RESP_OKAY;
                load_data <= merge(32'h0000_0000, w_data, w_strb);
                if (aw_addr == cic_pkg::ADDR_CTRL0) begin
                    ctrl[0] <= merge(ctrl[0], w_data, w_strb);
                end else if (aw_addr == cic_pkg::ADDR_CTRL1) begin
                    ctrl[1] <= merge(ctrl[1], w_data, w_strb);
                end else if (aw_addr == cic_pkg::ADDR_FILT) begin
                    filt_cfg <= merge(filt_cfg, w_data, w_strb);
                end else if (aw_addr == cic_pkg::ADDR_ROUTE) begin
                    route_direct <= N_IN'(merge(32'(route_direct), w_data, w_strb));
                end else if (aw_addr == cic_pkg::ADDR_CNT0) begin
                    cnt_load[0] <= 1'b1;
                end else if (aw_addr == cic_pkg::ADDR_CNT1) begin
                    cnt_load[1] <= 1'b1;
                end else if (aw_addr != cic_pkg::ADDR_LATCH0 && aw_addr != cic_pkg::ADDR_LATCH1
                             && aw_addr != cic_pkg::ADDR_STATUS) begin
                    s_axi_bresp <= cic_pkg::RESP_SLVERR;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= cic_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= cic_pkg::RESP_OKAY;
            if (s_axi_araddr[7:0] == cic_pkg::ADDR_CTRL0) begin
                s_axi_rdata <= ctrl[0];
            end else if (s_axi_araddr[7:0] == cic_pkg::ADDR_CTRL1) begin
                s_axi_rdata <= ctrl[1];
            end else if (s_axi_araddr[7:0] == cic_pkg::ADDR_FILT) begin
                s_axi_rdata <= filt_cfg;
            end else if (s_axi_araddr[7:0] == cic_pkg::ADDR_ROUTE) begin
                s_axi_rdata <= 32'(route_direct);
            end else if (s_axi_araddr[7:0] == cic_pkg::ADDR_CNT0) begin
                s_axi_rdata <= count_value[0];
            end else if (s_axi_araddr[7:0] == cic_pkg::ADDR_CNT1) begin
                s_axi_rdata <= count_value[1];
            end else if (s_axi_araddr[7:0] == cic_pkg::ADDR_LATCH0) begin
                s_axi_rdata <= latch_value[0];
            end else if (s_axi_araddr[7:0] == cic_pkg::ADDR_LATCH1) begin
                s_axi_rdata <= latch_value[1];
            end else if (s_axi_araddr[7:0] == cic_pkg::ADDR_STATUS) begin
                s_axi_rdata <= {24'h000000, 2'b00, internal_out, 2'b00, 2'(N_IN > 0 ? filtered_in[1:0] : 2'b00)};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= cic_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timebases: filter clock enable and internal timebase levels.

    logic [2:0] filt_div;
    logic filt_tick;
    logic fast_tb;
    logic med_tb;
    logic slow_tb;
    logic [3:0] med_cnt;
    logic [9:0] slow_cnt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_div <= 3'h0;
            filt_tick <= 1'b0;
        end else begin
            filt_tick <= (filt_div == 3'(cic_pkg::FILT_DIV - 1));
            filt_div <= (filt_div == 3'(cic_pkg::FILT_DIV - 1)) ? 3'h0 : filt_div + 3'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_tb <= 1'b0;
            med_tb <= 1'b0;
            slow_tb <= 1'b0;
            med_cnt <= 4'h0;
            slow_cnt <= 10'h000;
        end else begin
            fast_tb <= !fast_tb;
            med_cnt <= (med_cnt == 4'(cic_pkg::MED_HALF - 1)) ? 4'h0 : med_cnt + 4'h1;
            slow_cnt <= (slow_cnt == 10'(cic_pkg::SLOW_HALF - 1)) ? 10'h000 : slow_cnt + 10'h001;
            if (med_cnt == 4'(cic_pkg::MED_HALF - 1)) begin
                med_tb <= !med_tb;
            end
            if (slow_cnt == 10'(cic_pkg::SLOW_HALF - 1)) begin
                slow_tb <= !slow_tb;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Debounce filters, one per input.

    logic [16:0] run [N_IN];

    for (genvar i = 0; i < N_IN; i++) begin : g_filt
        logic [1:0] setting;
        logic [16:0] need;
        assign setting = filt_cfg[(i % 16)*2 +: 2];
        always_comb begin
            case (cic_pkg::cic_filt_t'(setting))
                cic_pkg::CIC_FILT_SHORT: need = cic_pkg::FILT_N_SHORT;
                cic_pkg::CIC_FILT_MED: need = cic_pkg::FILT_N_MED;
                default: need = 17'(FILT_N_LONG);
            endcase
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                filtered_in[i] <= 1'b0;
                run[i] <= 17'h00000;
                trigger_bus_line[i] <= 1'b0;
            end else begin
                trigger_bus_line[i] <= route_direct[i] ? function_pin[i] : filtered_in[i];
                if (setting == cic_pkg::CIC_FILT_OFF) begin
                    filtered_in[i] <= function_pin[i];
                    run[i] <= 17'h00000;
                end else if (filt_tick) begin
                    if (function_pin[i] == filtered_in[i]) begin
                        run[i] <= 17'h00000;
                    end else if (run[i] + 17'h00001 >= need) begin
                        filtered_in[i] <= function_pin[i];
                        run[i] <= 17'h00000;
                    end else begin
                        run[i] <= run[i] + 17'h00001;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counters with prescaler, gate synchronization and latch.

    logic [1:0] tc_event;

    for (genvar c = 0; c < 2; c++) begin : g_cnt
        localparam int O = 1 - c;
        cic_pkg::cic_sync_t mode;
        logic src_lvl;
        logic src_prev;
        logic src_rise;
        logic src_fall;
        logic rise_dly;
        logic [2:0] pre_cnt;
        logic pre_out;
        logic step;
        logic gate_raw;
        logic gate_s;
        logic gate_prev;
        logic pending;
        logic sync_pt;
        logic ext;
        logic gate_edge;

        assign ext = (ctrl[c].src_sel == cic_pkg::CIC_SRC_EXT);
        always_comb begin
            if (ctrl[c].dcp || ctrl[c].position || ctrl[c].src_sel == cic_pkg::CIC_SRC_FAST) begin
                mode = cic_pkg::CIC_SYNC_FAST;
            end else if (!ext) begin
                mode = cic_pkg::CIC_SYNC_INT;
            end else begin
                mode = cic_pkg::CIC_SYNC_EXT;
            end
            case (ctrl[c].src_sel)
                cic_pkg::CIC_SRC_FAST: src_lvl = fast_tb;
                cic_pkg::CIC_SRC_MED: src_lvl = med_tb;
                cic_pkg::CIC_SRC_SLOW: src_lvl = slow_tb;
                cic_pkg::CIC_SRC_BACKPLANE: src_lvl = backplane_10mhz_clock;
                default: src_lvl = filtered_in[ctrl[c].src_idx % N_IN];
            endcase
            case (ctrl[c].gate_kind)
                cic_pkg::CIC_GATE_OUT: gate_raw = internal_out[O];
                cic_pkg::CIC_GATE_TC: gate_raw = terminal_count[O];
                default: gate_raw = filtered_in[ctrl[c].gate_idx % N_IN];
            endcase
            case (mode)
                cic_pkg::CIC_SYNC_FAST: sync_pt = ctrl[c].dcp ? 1'b1 : src_rise;
                cic_pkg::CIC_SYNC_INT: sync_pt = src_fall;
                default: sync_pt = rise_dly;
            endcase
        end
        assign gate_edge = sync_pt && gate_raw && !gate_s;
        assign src_rise = src_lvl && !src_prev;
        assign src_fall = !src_lvl && src_prev;
        // Prescaler output: bypassed unless the source is external.
        assign pre_out = !ext || ctrl[c].prescale == cic_pkg::CIC_PRE_NONE
                         || (ctrl[c].prescale == cic_pkg::CIC_PRE_DIV2 && pre_cnt[0])
                         || (ctrl[c].prescale == cic_pkg::CIC_PRE_DIV8 && pre_cnt == 3'h7);
        // Cascaded upper counter steps on the lower one's terminal count.
        assign step = ctrl[c].enable && ((c == 1 && ctrl[1].cascade) ? tc_event[0]
                                         : src_rise && pre_out);

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                src_prev <= 1'b0;
                rise_dly <= 1'b0;
                pre_cnt <= 3'h0;
            end else begin
                src_prev <= src_lvl;
                rise_dly <= src_rise;
                if (!ext || ctrl[c].prescale == cic_pkg::CIC_PRE_NONE) begin
                    pre_cnt <= 3'h0;
                end else if (src_rise) begin
                    pre_cnt <= pre_cnt + 3'h1;
                end
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                gate_s <= 1'b0;
                gate_prev <= 1'b0;
                pending <= 1'b0;
                latch_value[c] <= 32'h0000_0000;
                latch_valid[c] <= 1'b0;
            end else begin
                latch_valid[c] <= 1'b0;
                if (sync_pt) begin
                    gate_s <= gate_raw;
                    gate_prev <= gate_s;
                end
                if (ctrl[c].enable && ctrl[c].dcp && gate_s && !gate_prev && sync_pt) begin
                    latch_value[c] <= count_value[c];
                    latch_valid[c] <= 1'b1;
                    pending <= 1'b0;
                end else if (pending && src_rise) begin
                    latch_value[c] <= count_value[c];
                    latch_valid[c] <= 1'b1;
                    pending <= ctrl[c].enable && !ctrl[c].dcp && gate_edge;
                end else if (ctrl[c].enable && !ctrl[c].dcp && gate_edge) begin
                    pending <= 1'b1;
                end
            end
        end

        assign tc_event[c] = step && (ctrl[c].count_up ? &count_value[c] : ~|count_value[c]);

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                count_value[c] <= 32'h0000_0000;
                internal_out[c] <= 1'b0;
                terminal_count[c] <= 1'b0;
            end else begin
                terminal_count[c] <= tc_event[c];
                if (tc_event[c]) begin
                    internal_out[c] <= !internal_out[c];
                end
                if (cnt_load[c]) begin
                    count_value[c] <= load_data;
                end else if (step) begin
                    count_value[c] <= ctrl[c].count_up ? count_value[c] + 32'h1 : count_value[c] - 32'h1;
                end
            end
        end
    end

endmodule : cic_top

// File: hdl/cic_pkg.sv
package cic_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int FILT_CLK_HZ = 40_000_000;
    localparam int FILT_DIV = CLK_HZ / FILT_CLK_HZ;
    localparam int MED_TB_HZ = 20_000_000;
    localparam int SLOW_TB_HZ = 100_000;
    localparam int MED_HALF = CLK_HZ / MED_TB_HZ / 2;
    localparam int SLOW_HALF = CLK_HZ / SLOW_TB_HZ / 2;
    localparam logic [16:0] FILT_N_SHORT = 17'd5;
    localparam logic [16:0] FILT_N_MED = 17'd257;
    localparam int FILT_N_LONG = 101_800;
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_FILT = 8'h08;
    localparam logic [7:0] ADDR_ROUTE = 8'h0c;
    localparam logic [7:0] ADDR_CNT0 = 8'h10;
    localparam logic [7:0] ADDR_CNT1 = 8'h14;
    localparam logic [7:0] ADDR_LATCH0 = 8'h18;
    localparam logic [7:0] ADDR_LATCH1 = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
    localparam logic [31:0] FILT_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CIC_FILT_OFF = 2'b00,
        CIC_FILT_SHORT = 2'b01,
        CIC_FILT_MED = 2'b10,
        CIC_FILT_LONG = 2'b11
    } cic_filt_t;

    typedef enum logic [2:0] {
        CIC_SRC_FAST = 3'b000,
        CIC_SRC_MED = 3'b001,
        CIC_SRC_SLOW = 3'b010,
        CIC_SRC_BACKPLANE = 3'b011,
        CIC_SRC_EXT = 3'b100
    } cic_src_t;

    typedef enum logic [1:0] {
        CIC_PRE_NONE = 2'b00,
        CIC_PRE_DIV2 = 2'b01,
        CIC_PRE_DIV8 = 2'b10
    } cic_pre_t;

    typedef enum logic [1:0] {
        CIC_GATE_PIN = 2'b00,
        CIC_GATE_OUT = 2'b01,
        CIC_GATE_TC = 2'b10
    } cic_gate_t;

    typedef enum logic [1:0] {
        CIC_SYNC_FAST = 2'b00,
        CIC_SYNC_INT = 2'b01,
        CIC_SYNC_EXT = 2'b10
    } cic_sync_t;

    // Counter control word, bit 31 downward.
    typedef struct packed {
        logic [13:0] spare;
        logic cascade;
        logic position;
        logic dcp;
        cic_gate_t gate_kind;
        logic [2:0] gate_idx;
        logic [2:0] src_idx;
        cic_src_t src_sel;
        cic_pre_t prescale;
        logic count_up;
        logic enable;
    } cic_ctrl_t;
endpackage : cic_pkg

// File: bench/cic_line_model.sv
`timescale 1ns/1ps
module cic_line_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire logic [7:0] npulse,
    input wire logic [7:0] hi,
    output logic line,
    output logic busy
);
    logic [7:0] left;
    logic [7:0] cnt;
    // Six low cycles plus at least four high keep the source at or under 20 MHz.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line <= 1'b0;
            busy <= 1'b0;
            left <= 8'h0;
            cnt <= 8'h0;
        end else if (!busy) begin
            busy <= go;
            left <= npulse;
            cnt <= 8'h0;
        end else if (line) begin
            cnt <= cnt + 8'h1;
            if (cnt + 8'h1 >= hi) begin
                line <= 1'b0;
                cnt <= 8'h0;
                left <= left - 8'h1;
            end
        end else if (left == 8'h0) begin
            busy <= 1'b0;
        end else begin
            cnt <= cnt + 8'h1;
            if (cnt == 8'h5) begin
                line <= 1'b1;
                cnt <= 8'h0;
            end
        end
    end
endmodule : cic_line_model

// File: bench/cic_top_asserts.sv
`timescale 1ns/1ps
module cic_top_asserts #(
    parameter int N_IN = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [N_IN-1:0] function_pin,
    input wire logic [N_IN-1:0] filtered_in,
    input wire logic [1:0] terminal_count,
    input wire logic [1:0] latch_valid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer not held");
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_b_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_err;
        s_axi_rvalid && s_axi_rresp == cic_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("error read carries data");
    property p_rise;
        (!function_pin[0]) [*8] |=> !$rose(filtered_in[0]);
    endproperty
    a_rise: assert property (p_rise) else $error("filter rose on low input");
    property p_fall;
        function_pin[0] [*8] |=> !$fell(filtered_in[0]);
    endproperty
    a_fall: assert property (p_fall) else $error("filter fell on high input");
    property p_tc;
        terminal_count[0] |=> !terminal_count[0];
    endproperty
    a_tc: assert property (p_tc) else $error("terminal count too long");
    property p_lv;
        latch_valid[0] |=> !latch_valid[0];
    endproperty
    a_lv: assert property (p_lv) else $error("latch pulse too long");
    c_tc: cover property (terminal_count[0]);
    c_lv: cover property (latch_valid[0]);
    c_filt: cover property ($rose(filtered_in[0]));
endmodule : cic_top_asserts
bind cic_top cic_top_asserts #(.N_IN(N_IN)) u_asserts (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .function_pin(function_pin), .filtered_in(filtered_in), .terminal_count(terminal_count),
    .latch_valid(latch_valid));

// File: bench/counter_input_conditioning_tb.sv
`timescale 1ns/1ps
module counter_input_conditioning_tb;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, terminal_count, latch_valid;
    logic [31:0] s_axi_rdata;
    logic [7:0] pins = 8'h0, npulse = 8'h0, hi = 8'h4;
    logic [7:0] function_pin, filtered_in, trigger_bus_line;
    logic src_line, src_busy, go = 1'b0, tc_seen = 1'b0, bp = 1'b0;
    logic [33:0] q [$];
    logic [5:0] lv = 6'h15, ex = 6'h1c;
    int du [6] = '{15, 40, 60, 10, 40, 60};
    int failures = 0, checks = 0, seed = 32'hdc9d, n;
    cic_pkg::cic_ctrl_t c;
    assign function_pin = {pins[7:3], src_line, pins[1:0]};
    always #2.5 aclk = ~aclk;
    cic_top #(.N_IN(8), .FILT_N_LONG(20)) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .function_pin(function_pin),
        .backplane_10mhz_clock(bp), .filtered_in(filtered_in), .trigger_bus_line(trigger_bus_line),
        .internal_out(), .terminal_count(terminal_count), .latch_valid(latch_valid),
        .count_value(), .latch_value());
    cic_line_model u_src (.aclk(aclk), .aresetn(aresetn), .go(go), .npulse(npulse), .hi(hi),
        .line(src_line), .busy(src_busy));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic summarize;
        if (failures == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        q.push_back({r, 32'h0});
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) s_axi_bready <= 1'b0;
        end while (s_axi_bready);
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        q.push_back(e);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) s_axi_rready <= 1'b0;
        end while (s_axi_rready);
        @(posedge aclk);
    endtask : rd
    task automatic pulses(input int k);
        npulse <= k[7:0];
        hi <= 8'h4 + (8'($random(seed)) & 8'hf);
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        do @(posedge aclk); while (src_busy);
        repeat (8) @(posedge aclk);
    endtask : pulses
    ////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) chk("bresp", q.pop_front(), {s_axi_bresp, 32'h0});
        if (s_axi_rvalid && s_axi_rready) chk("rdata", q.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (terminal_count[0]) tc_seen <= 1'b1;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(cic_pkg::ADDR_CTRL0, {cic_pkg::RESP_OKAY, cic_pkg::CTRL_RESET});
        rd(cic_pkg::ADDR_FILT, {cic_pkg::RESP_OKAY, 32'h0});
        rd(8'h40, {cic_pkg::RESP_SLVERR, 32'h0});
        wr(8'h40, 32'h1, cic_pkg::RESP_SLVERR);
        pins[1] <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("filt1", 34'h1, {33'h0, filtered_in[1]});
        pins[1] <= 1'b0;
        wr(cic_pkg::ADDR_FILT, 32'h5, cic_pkg::RESP_OKAY);
        wr(cic_pkg::ADDR_ROUTE, 32'h2, cic_pkg::RESP_OKAY);
        pins[1] <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("route", 34'h2, {32'h0, trigger_bus_line[1], filtered_in[1]});
        pins[1] <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            pins[0] <= lv[i];
            repeat (du[i]) @(posedge aclk);
            chk("filt0", {33'h0, ex[i]}, {33'h0, filtered_in[0]});
        end
        c = '0;
        c.enable = 1'b1;
        c.count_up = 1'b1;
        c.src_sel = cic_pkg::CIC_SRC_EXT;
        c.src_idx = 3'h2;
        c.gate_idx = 3'h3;
        c.dcp = 1'b1;
        wr(cic_pkg::ADDR_CTRL0, c, cic_pkg::RESP_OKAY);
        wr(cic_pkg::ADDR_CNT0, 32'hffff_fffe, cic_pkg::RESP_OKAY);
        wr(cic_pkg::ADDR_CTRL1, 32'h0002_0003, cic_pkg::RESP_OKAY);
        pulses(5);
        rd(cic_pkg::ADDR_CNT0, {cic_pkg::RESP_OKAY, 32'h3});
        chk("tc", 34'h1, {33'h0, tc_seen});
        rd(cic_pkg::ADDR_CNT1, {cic_pkg::RESP_OKAY, 32'h1});
        rd(cic_pkg::ADDR_STATUS, {cic_pkg::RESP_OKAY, 32'h10});
        pins[3] <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(cic_pkg::ADDR_LATCH0, {cic_pkg::RESP_OKAY, 32'h3});
        pins[3] <= 1'b0;
        n = 2 * (1 + ($random(seed) & 3));
        c.dcp = 1'b0;
        c.prescale = cic_pkg::CIC_PRE_DIV2;
        wr(cic_pkg::ADDR_CTRL0, c, cic_pkg::RESP_OKAY);
        wr(cic_pkg::ADDR_CNT0, 32'h100, cic_pkg::RESP_OKAY);
        pulses(n);
        rd(cic_pkg::ADDR_CNT0, {cic_pkg::RESP_OKAY, 32'h100 + 32'(n / 2)});
        pins[3] <= 1'b1;
        pulses(2);
        rd(cic_pkg::ADDR_LATCH0, {cic_pkg::RESP_OKAY, 32'h100 + 32'(n / 2)});
        summarize();
    end
endmodule : counter_input_conditioning_tb
